// *** cgr_pkg.sv ***
// shared constants, types and register map for the colour gain / row noise block
`default_nettype none
package cgr_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_RED_GAIN    = 6'h2d;
	localparam logic [5:0] IDX_GREEN2_GAIN = 6'h2e;
	localparam logic [5:0] IDX_GLOBAL_GAIN = 6'h2f;
	localparam logic [5:0] IDX_ROW_NOISE   = 6'h30;
	// gain field layout
	localparam int DIG_LSB  = 9;
	localparam int ANA_LSB  = 7;
	localparam int INIT_W   = 7;
	localparam int GAIN_W   = 12;
	localparam int TOTAL_W  = 12;   // gain in units of 0.03125
	localparam logic [11:0] GAIN_RESET = 12'h020;
	// row noise control layout
	localparam int RN_FRAMEWISE = 15;
	localparam int RN_THR_LSB   = 12;
	localparam int RN_SRC       = 11;
	localparam int RN_EN        = 10;
	localparam logic [15:0] RN_RESET = 16'h042a;
	localparam logic [15:0] RN_MASK  = 16'hffff;
	// frame-wise mode uses the first two row pairs of a frame
	localparam logic [1:0] FW_ROWS = 2'h2;
	localparam int PIX_W = 10;
	localparam logic [PIX_W:0] PIX_MAX = 11'h3ff;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// bayer colour index
	typedef enum logic [1:0] {
		CGR_GREEN1 = 2'b00,
		CGR_RED    = 2'b01,
		CGR_BLUE   = 2'b10,
		CGR_GREEN2 = 2'b11
	} cgr_color_e;

	// one pixel with its colour
	typedef struct packed {
		cgr_color_e       color;
		logic [PIX_W-1:0] data;
	} cgr_pix_s;
endpackage
`default_nettype wire

// *** cgr_gain_calc.sv ***
// total gain of one colour from its gain register fields
`timescale 1ns/10ps
`default_nettype none
module cgr_gain_calc
	import cgr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [GAIN_W-1:0] gain_field,
	output logic      [TOTAL_W-1:0] total_gain
);
	// number of doubling bits set, five at most
	logic [2:0] dbl_cnt;

	// each digital or analog bit doubles the gain; initial lsb is 1/32
	always_comb begin
		dbl_cnt = 3'(gain_field[DIG_LSB]) + 3'(gain_field[DIG_LSB+1])
			+ 3'(gain_field[DIG_LSB+2])                           // [R1]
			+ 3'(gain_field[ANA_LSB]) + 3'(gain_field[ANA_LSB+1]); // [R2]
		total_gain = TOTAL_W'(gain_field[INIT_W-1:0]) << dbl_cnt;  // [R3]
	end

	a_unity_scale: assert property (@(posedge clk) disable iff (rst)
		gain_field[11:7] == 5'h00 |-> total_gain == 12'(gain_field[6:0]))
		else $error("initial gain not passed unchanged"); // [R3]
	a_full_doubling: assert property (@(posedge clk) disable iff (rst)
		gain_field[11:7] == 5'h1f |-> total_gain[4:0] == 5'h00
		&& total_gain[11:5] == gain_field[6:0])
		else $error("five doubling bits not x32"); // [R1]
endmodule
`default_nettype wire

// *** cgr_color_gain_row_noise.sv ***
// colour gain registers, frame-synced gain update and row noise correction
//
// Function
// R1 - digital gain bits each double total gain
// R2 - analog gain bits each double analog gain
// R3 - initial gain is value times 1/32, reset 0x20
// R4 - gain writes apply at frame start, no bad frame
// R5 - global gain write loads all four colour gains
// R6 - global gain read returns green1 gain
// R7 - bit clear: correct every colour every row
// R8 - bit set: first two row pairs, reused per frame
// R9 - gain at/above threshold uses dark column average
// R10 - threshold compared per colour; else source bit chooses
// R11 - source bit: 0 threshold mean, 1 frame average
// R12 - subtract dark average, add ten-bit constant
// R13 - enable bit: 0 normal, 1 cancel; resets one
// R14 - row noise constant resets to 0x2a
`timescale 1ns/10ps
`default_nettype none
module cgr_color_gain_row_noise
	import cgr_pkg::*;
#(
	parameter int ADDR_W    = 8,
	parameter int DARK_LOG2 = 3   // dark columns per colour per row, log2
) (
	input  wire logic               clk,
	input  wire logic               rst,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// frame timing
	input  wire logic               frame_start,
	input  wire logic               row_start,
	// dark column samples of the current row
	input  wire logic               dark_valid,
	input  wire cgr_pix_s           dark_in,
	// black level references per colour (green1, red, blue, green2)
	input  wire logic [4*PIX_W-1:0] bl_thr_mean,
	input  wire logic [4*7-1:0]     bl_frame_avg,
	// active pixel stream
	input  wire logic               pix_valid,
	input  wire cgr_pix_s           pix_in,
	output logic                    pix_out_valid,
	output cgr_pix_s                pix_out,
	// gains applied this frame, units of 0.03125
	output logic [4*TOTAL_W-1:0]    total_gain,
	output logic                    bad_frame
);
	localparam int SUM_W = PIX_W + DARK_LOG2;

	logic [GAIN_W-1:0]  pend_gain [4];   // software view
	logic [GAIN_W-1:0]  act_gain  [4];   // in use this frame
	logic [15:0]        rn_ctrl;         // row noise control
	logic [TOTAL_W-1:0] gain_calc [4];   // combinational totals
	logic [SUM_W-1:0]   dark_sum  [4];   // running dark sums
	logic [DARK_LOG2:0] dark_cnt  [4];   // dark samples this row
	logic [PIX_W-1:0]   dark_avg  [4];   // latched row averages
	logic [1:0]         row_cnt;         // rows since frame start, saturates
	logic               rn_dirty;        // bad-frame field changed
	// write channel holding
	logic               aw_held;
	logic               w_held;
	logic [5:0]         aw_idx;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               do_write;
	logic [15:0]        wr_val;
	logic [5:0]         ar_idx;
	logic [31:0]        next_rdata;
	logic               next_rerr;
	// pixel path
	logic [PIX_W-1:0]   sub_val;
	logic               hi_gain;
	logic signed [PIX_W+2:0] corr;
	logic               fw_mode;
	logic               rn_en;
	logic [9:0]         rn_const;

	assign fw_mode  = rn_ctrl[RN_FRAMEWISE];
	assign rn_en    = rn_ctrl[RN_EN];
	assign rn_const = rn_ctrl[9:0];

	// handshake outputs: one write and one read in flight
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	// merge byte lanes over the old value; only lanes 0 and 1 exist
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	always_comb begin
		unique case (aw_idx)
			IDX_RED_GAIN:    wr_val = merge({4'h0, pend_gain[CGR_RED]},
				w_data, w_strb);
			IDX_GREEN2_GAIN: wr_val = merge({4'h0, pend_gain[CGR_GREEN2]},
				w_data, w_strb);
			IDX_GLOBAL_GAIN: wr_val = merge({4'h0, pend_gain[CGR_GREEN1]},
				w_data, w_strb);
			IDX_ROW_NOISE:   wr_val = merge(rn_ctrl, w_data, w_strb);
			default:         wr_val = 16'h0000;
		endcase
	end

	// address and data may arrive in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_idx  <= 6'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx  <= s_axi_awaddr[7:2];
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response; unmapped index answers slverr
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_idx == IDX_RED_GAIN
				|| aw_idx == IDX_GREEN2_GAIN || aw_idx == IDX_GLOBAL_GAIN
				|| aw_idx == IDX_ROW_NOISE) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// pending gains: software-visible, held until frame start
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int c = 0; c < 4; c++) pend_gain[c] <= GAIN_RESET; // [R3]
		end else if (do_write) begin
			if (aw_idx == IDX_GLOBAL_GAIN) begin
				// one value fans out to every colour
				for (int c = 0; c < 4; c++)
					pend_gain[c] <= wr_val[11:0]; // [R5]
			end else if (aw_idx == IDX_RED_GAIN) begin
				pend_gain[CGR_RED] <= wr_val[11:0];
			end else if (aw_idx == IDX_GREEN2_GAIN) begin
				pend_gain[CGR_GREEN2] <= wr_val[11:0];
			end
		end
	end

	// active gains change only at frame start, never mid-frame
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int c = 0; c < 4; c++) act_gain[c] <= GAIN_RESET;
		end else if (frame_start) begin
			for (int c = 0; c < 4; c++) act_gain[c] <= pend_gain[c]; // [R4]
		end
	end

	// row noise control applies at once; some fields spoil the frame
	always_ff @(posedge clk) begin
		if (rst) begin
			rn_ctrl  <= RN_RESET; // [R13] [R14]
			rn_dirty <= 1'b0;
		end else begin
			if (do_write && aw_idx == IDX_ROW_NOISE) begin
				rn_ctrl <= wr_val & RN_MASK;
			end
			// gain writes never mark the frame bad, only these fields
			if (do_write && aw_idx == IDX_ROW_NOISE
				&& wr_val[11:0] != rn_ctrl[11:0]) begin
				rn_dirty <= 1'b1; // [R4]
			end else if (frame_start) begin
				rn_dirty <= 1'b0;
			end
		end
	end

	// flag covers the frame in which the change took effect and the whole frame after it
	always_ff @(posedge clk) begin
		if (rst) begin
			bad_frame <= 1'b0;
		end else if (frame_start) begin
			bad_frame <= rn_dirty;
		end else if (rn_dirty) begin
			bad_frame <= 1'b1;
		end
	end

	// read data; the global address shows green1's gain
	assign ar_idx = s_axi_araddr[7:2];
	always_comb begin
		next_rerr = 1'b0;
		unique case (ar_idx)
			IDX_RED_GAIN:    next_rdata = {20'h0, pend_gain[CGR_RED]};
			IDX_GREEN2_GAIN: next_rdata = {20'h0, pend_gain[CGR_GREEN2]};
			IDX_GLOBAL_GAIN: next_rdata = {20'h0, pend_gain[CGR_GREEN1]}; // [R6]
			IDX_ROW_NOISE:   next_rdata = {16'h0, rn_ctrl};
			default: begin
				next_rdata = 32'h0000_0000;
				next_rerr  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// per-colour gain totals, registered for output
	for (genvar g = 0; g < 4; g++) begin : g_gain
		cgr_gain_calc u_calc (
			.clk        (clk),
			.rst        (rst),
			.gain_field (act_gain[g]),
			.total_gain (gain_calc[g])
		);
		always_ff @(posedge clk) begin
			if (rst) begin
				total_gain[g*TOTAL_W +: TOTAL_W] <= TOTAL_W'(0);
			end else begin
				total_gain[g*TOTAL_W +: TOTAL_W] <= gain_calc[g];
			end
		end
	end

	// row counter; frame-wise mode only learns in the first rows
	always_ff @(posedge clk) begin
		if (rst || frame_start) begin
			row_cnt <= 2'h0;
		end else if (row_start && row_cnt != 2'h3) begin
			row_cnt <= row_cnt + 2'h1;
		end
	end

	// dark column averaging; count is a power of two, so no divider
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int c = 0; c < 4; c++) begin
				dark_sum[c] <= SUM_W'(0);
				dark_cnt[c] <= '0;
				dark_avg[c] <= PIX_W'(0);
			end
		end else if (row_start || frame_start) begin
			for (int c = 0; c < 4; c++) begin
				dark_sum[c] <= SUM_W'(0);
				dark_cnt[c] <= '0;
			end
		end else if (dark_valid && !dark_cnt[dark_in.color][DARK_LOG2]) begin
			dark_sum[dark_in.color] <= dark_sum[dark_in.color]
				+ SUM_W'(dark_in.data);
			dark_cnt[dark_in.color] <= dark_cnt[dark_in.color] + 1'b1;
			// last sample of the row closes the average
			if (dark_cnt[dark_in.color] == (DARK_LOG2+1)'((1 << DARK_LOG2) - 1)
				&& (!fw_mode || row_cnt < FW_ROWS)) begin // [R7] [R8]
				dark_avg[dark_in.color] <= PIX_W'((dark_sum[dark_in.color]
					+ SUM_W'(dark_in.data)) >> DARK_LOG2);
			end
		end
	end

	// subtraction source chosen per colour by its own analog gain
	always_comb begin
		hi_gain = {1'b0, act_gain[pix_in.color][ANA_LSB+1:ANA_LSB]}
			>= rn_ctrl[RN_THR_LSB+2:RN_THR_LSB]; // [R9] [R10]
		if (hi_gain) begin
			sub_val = dark_avg[pix_in.color]; // [R9]
		end else if (rn_ctrl[RN_SRC]) begin
			// frame average is stale by one offset adjustment
			sub_val = PIX_W'(bl_frame_avg[pix_in.color*7 +: 7]); // [R11]
		end else begin
			sub_val = bl_thr_mean[pix_in.color*PIX_W +: PIX_W]; // [R11]
		end
		corr = $signed({3'b000, pix_in.data}) - $signed({3'b000, sub_val})
			+ $signed({3'b000, rn_const}); // [R12]
	end

	// output stage, clamped to the pixel range
	always_ff @(posedge clk) begin
		if (rst) begin
			pix_out_valid <= 1'b0;
			pix_out       <= '0;
		end else begin
			pix_out_valid <= pix_valid;
			if (pix_valid) begin
				pix_out.color <= pix_in.color;
				if (!rn_en) begin
					pix_out.data <= pix_in.data; // [R13]
				end else if (corr < 0) begin
					pix_out.data <= PIX_W'(0);
				end else if (corr > $signed({2'b00, PIX_MAX})) begin
					pix_out.data <= PIX_MAX[PIX_W-1:0];
				end else begin
					pix_out.data <= corr[PIX_W-1:0]; // [R12]
				end
			end
		end
	end

	a_gain_frame_hold: assert property (@(posedge clk) disable iff (rst)
		!frame_start |=> $stable(act_gain[CGR_RED])) // [R4]
		else $error("active gain moved outside frame start");
	a_gain_frame_take: assert property (@(posedge clk) disable iff (rst)
		frame_start |=> act_gain[CGR_GREEN2] == $past(pend_gain[CGR_GREEN2]))
		else $error("pending gain not applied at frame start"); // [R4]
	a_global_fanout: assert property (@(posedge clk) disable iff (rst)
		do_write && aw_idx == IDX_GLOBAL_GAIN |=> pend_gain[0] == pend_gain[1]
		&& pend_gain[2] == pend_gain[3] && pend_gain[0] == pend_gain[3])
		else $error("global write did not reach all colours"); // [R5]
	a_global_readback: assert property (@(posedge clk) disable iff (rst)
		s_axi_arvalid && s_axi_arready && ar_idx == IDX_GLOBAL_GAIN
		&& !do_write |=> s_axi_rdata[11:0] == pend_gain[CGR_GREEN1]) // [R6]
		else $error("global read not green1 value");
	a_bypass_path: assert property (@(posedge clk) disable iff (rst)
		pix_valid && !rn_en |=> pix_out.data == $past(pix_in.data)) // [R13]
		else $error("bypass altered pixel");
	a_corr_math: assert property (@(posedge clk) disable iff (rst)
		pix_valid && rn_en && corr >= 0 && corr <= 1023
		|=> 11'(pix_out.data) + 11'($past(sub_val))
		== 11'($past(pix_in.data)) + 11'($past(rn_const))) // [R12]
		else $error("row noise correction arithmetic wrong");
	a_hi_gain_src: assert property (@(posedge clk) disable iff (rst)
		pix_valid && rn_en && act_gain[pix_in.color][8:7] == 2'b11
		&& rn_ctrl[14:12] <= 3'h3 && rn_const == 10'h000
		&& pix_in.data >= dark_avg[pix_in.color]
		|=> pix_out.data == $past(pix_in.data) - $past(dark_avg[pix_in.color]))
		else $error("high gain did not use dark average"); // [R9]
	a_low_src_sel: assert property (@(posedge clk) disable iff (rst)
		pix_valid && rn_ctrl[14:12] > 3'h3 && !rn_ctrl[RN_SRC]
		|-> sub_val == bl_thr_mean[pix_in.color*PIX_W +: PIX_W]) // [R10]
		else $error("low gain source not threshold mean");
	a_framewise_freeze: assert property (@(posedge clk) disable iff (rst)
		fw_mode && row_cnt >= FW_ROWS && !frame_start
		|=> $stable(dark_avg[CGR_RED])) // [R8]
		else $error("frame-wise average recalculated mid-frame");
	a_reset_values: assert property (@(posedge clk)
		$past(rst) |-> rn_ctrl == RN_RESET && pend_gain[CGR_RED] == 12'h020)
		else $error("reset values wrong"); // [R14]

	c_global_write: cover property (@(posedge clk) disable iff (rst)
		do_write && aw_idx == IDX_GLOBAL_GAIN);
	c_frame_apply: cover property (@(posedge clk) disable iff (rst)
		frame_start && pend_gain[CGR_RED] != act_gain[CGR_RED]);
	c_framewise_pix: cover property (@(posedge clk) disable iff (rst)
		pix_valid && rn_en && fw_mode && row_cnt == 2'h3);
	c_clamp_low: cover property (@(posedge clk) disable iff (rst)
		pix_valid && rn_en && corr < 0);
endmodule
`default_nettype wire

// *** cgr_color_gain_row_noise_tb_top.sv ***
// self-checking bench for the colour gain and row noise block
`timescale 1ns/10ps
`default_nettype none
module cgr_color_gain_row_noise_tb_top import cgr_pkg::*;;
	localparam int DL = 3;               // dark samples per row, log2
	logic        clk = 1'b0;             // 10 MHz clock
	logic        rst = 1'b1;             // sync reset, active high
	logic [7:0]  awaddr, araddr;         // bus addresses
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;                  // write data
	logic [3:0]  wstrb;                  // byte lanes
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;           // responses
	logic [31:0] rdata;                  // read data
	logic        fs, rs, dv, pv;         // frame, row, dark, pixel strobes
	cgr_pix_s    dk, px, pix_out;        // dark in, pixel in, pixel out
	logic        pix_out_valid, bad_frame;
	logic [39:0] thr_mean;               // per-colour threshold means
	logic [27:0] fr_avg;                 // per-colour frame averages
	logic [47:0] total_gain;             // applied gains
	logic [11:0] pend [4];               // written gains
	logic [11:0] act [4];                // gains in force this frame
	logic [15:0] ctrl;                   // row noise control model
	logic [31:0] seed;                   // lfsr state
	logic [33:0] rd_q [$];               // expected {rresp, rdata}
	logic [1:0]  b_q [$];                // expected bresp
	cgr_pix_s    px_q [$];               // expected corrected pixels
	int          num_errors, samples_checked;

	cgr_color_gain_row_noise #(.ADDR_W(8), .DARK_LOG2(DL)) i_dut (
		.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .frame_start(fs), .row_start(rs),
		.dark_valid(dv), .dark_in(dk), .bl_thr_mean(thr_mean),
		.bl_frame_avg(fr_avg), .pix_valid(pv), .pix_in(px),
		.pix_out_valid(pix_out_valid), .pix_out(pix_out),
		.total_gain(total_gain), .bad_frame(bad_frame)
	);

	// free-running clock, 100 ns period
	always #50 clk = ~clk;

	// galois-free shift register step for the random stream
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// total gain in 1/32 units: each set digital or analog gain bit (7 to 11) doubles
	function automatic logic [11:0] tg(input logic [11:0] g);
		int n;
		n = g[7] + g[8] + g[9] + g[10] + g[11];
		return 12'({5'h0, g[6:0]} << n);
	endfunction

	// expected total gain bus, colour c at bits c*12
	function automatic logic [47:0] exp_total();
		return {tg(act[3]), tg(act[2]), tg(act[1]), tg(act[0])};
	endfunction

	// one comparison; four-state safe
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic report_and_stop();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// bus write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
			input logic [1:0] e);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_q.push_back(e);
		while (!(ta && tw)) begin
			@(negedge clk);
			if (awvalid && awready) ta = 1'b1;
			if (wvalid && wready) tw = 1'b1;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		do @(negedge clk); while (!bvalid);
		@(posedge clk);
		bready <= 1'b0;
	endtask

	// bus read with the expected {rresp, rdata} noted first
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rd_q.push_back(e);
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		@(posedge clk);
		rready <= 1'b0;
	endtask

	// one-cycle frame and row strobes
	task automatic tick(input logic f, input logic r);
		@(posedge clk);
		fs <= f;
		rs <= r;
		@(posedge clk);
		fs <= 1'b0;
		rs <= 1'b0;
	endtask

	// one row's dark samples of a colour; returns their mean
	task automatic dark_row(input cgr_color_e c, output logic [9:0] avg);
		int s;
		s = 0;
		for (int k = 0; k < (1 << DL); k++) begin
			seed = lfsr(seed);
			@(posedge clk);
			dv <= 1'b1;
			dk <= {c, seed[9:0]};
			s += seed[9:0];
		end
		@(posedge clk);
		dv <= 1'b0;
		avg = 10'(s >> DL);
		repeat (2) @(posedge clk);
	endtask

	// one pixel; expected value from gains, control and references
	task automatic pixel(input cgr_color_e c, input logic [9:0] d,
			input logic [9:0] dav);
		int x, ci;
		cgr_pix_s e;
		ci = c;
		if ({1'b0, act[ci][8:7]} >= ctrl[14:12]) x = dav;
		else if (ctrl[11]) x = fr_avg[ci*7+:7];
		else x = thr_mean[ci*10+:10];
		x = int'(d) - x + int'(ctrl[9:0]);
		x = x < 0 ? 0 : (x > 1023 ? 1023 : x);   // output saturates
		e = {c, ctrl[10] ? x[9:0] : d};
		@(posedge clk);
		pv <= 1'b1;
		px <= {c, d};
		px_q.push_back(e);
		@(posedge clk);
		pv <= 1'b0;
	endtask

	// watcher: takes the oldest note when a result shows up
	always @(negedge clk) begin
		if (rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
		if (bvalid && bready) chk(bresp, b_q.pop_front());
		if (pix_out_valid) chk(pix_out, px_q.pop_front());
	end

	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		logic [15:0] cfg [4];
		logic [11:0] v;
		logic [7:0]  a;
		logic [9:0]  dr, dg, d2;
		// last setting lifts the threshold above every analog gain
		cfg = '{16'h2555, 16'h2d55, 16'h2155, 16'h57ff};
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{fs, rs, dv, pv} = '0;
		{awaddr, araddr, wdata, dk, px} = '0;
		wstrb = 4'hf;
		seed = 32'hd52d36d4;
		thr_mean = {seed, seed[7:0]};
		seed = lfsr(seed);
		fr_avg = seed[27:0];
		num_errors = 0;
		samples_checked = 0;
		ctrl = 16'h042a;
		for (int c = 0; c < 4; c++) begin
			pend[c] = GAIN_RESET;
			act[c] = GAIN_RESET;
		end
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(total_gain, exp_total());
		chk(bad_frame, 1'b0);
		rd({IDX_RED_GAIN, 2'b00}, 34'h20);
		rd({IDX_GREEN2_GAIN, 2'b00}, 34'h20);
		rd({IDX_GLOBAL_GAIN, 2'b00}, 34'h20);
		rd({IDX_ROW_NOISE, 2'b00}, 34'h042a);
		rd(8'h00, {RESP_SLVERR, 32'h0});
		// random gains through each register, applied at frame start
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			v = seed[11:0];
			a = {(i % 3 == 0) ? IDX_RED_GAIN :
				(i % 3 == 1) ? IDX_GREEN2_GAIN : IDX_GLOBAL_GAIN, 2'b00};
			wr(a, {4'h0, v}, RESP_OKAY);
			if (i % 3 == 0) pend[CGR_RED] = v;
			else if (i % 3 == 1) pend[CGR_GREEN2] = v;
			else for (int c = 0; c < 4; c++) pend[c] = v;
			rd(a, {22'h0, (i % 3 == 2) ? pend[CGR_GREEN1] : v});
			rd({IDX_GLOBAL_GAIN, 2'b00}, {22'h0, pend[CGR_GREEN1]});
			chk(total_gain, exp_total());
			tick(1'b1, 1'b0);
			repeat (2) @(posedge clk);
			for (int c = 0; c < 4; c++) act[c] = pend[c];
			chk(total_gain, exp_total());
			chk(bad_frame, 1'b0);
		end
		// red high analog gain, green2 low: threshold per colour
		wr({IDX_GLOBAL_GAIN, 2'b00}, 16'h0020, RESP_OKAY);
		wr({IDX_RED_GAIN, 2'b00}, 16'h01a0, RESP_OKAY);
		tick(1'b1, 1'b0);
		for (int c = 0; c < 4; c++) act[c] = 12'h020;
		act[CGR_RED] = 12'h1a0;
		for (int j = 0; j < 4; j++) begin
			wr({IDX_ROW_NOISE, 2'b00}, cfg[j], RESP_OKAY);
			ctrl = cfg[j];
			rd({IDX_ROW_NOISE, 2'b00}, {18'h0, cfg[j]});
			if (j == 0) chk(bad_frame, 1'b1);
			tick(1'b0, 1'b1);
			dark_row(CGR_RED, dr);
			dark_row(CGR_GREEN2, dg);
			seed = lfsr(seed);
			pixel(CGR_RED, seed[9:0], dr);
			pixel(CGR_GREEN2, seed[19:10], dg);
			pixel(CGR_GREEN2, 10'h000, dg);
		end
		// frame-wise: only the first rows of a frame refresh the average
		ctrl = 16'h8440;
		wr({IDX_ROW_NOISE, 2'b00}, ctrl, RESP_OKAY);
		tick(1'b1, 1'b0);
		tick(1'b0, 1'b1);
		dark_row(CGR_RED, dr);
		pixel(CGR_RED, 10'h200, dr);
		tick(1'b0, 1'b1);
		dark_row(CGR_RED, d2);
		pixel(CGR_RED, 10'h200, dr);
		ctrl = 16'h0440;
		wr({IDX_ROW_NOISE, 2'b00}, ctrl, RESP_OKAY);
		tick(1'b0, 1'b1);
		dark_row(CGR_RED, d2);
		pixel(CGR_RED, 10'h200, d2);
		repeat (5) @(posedge clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
